// ### acl4_layer4_top.v
// How it works
// - Range mode: off, either, inside, outside
// - Protocol byte split over bytes four, five
// - Flag enable applies masked flag compare
// - Command, offset, data registers reach entries
// - Priority mode keeps, compares or replaces on tagged frames
// - Entry priority held in byte ten
// - Remark enable rewrites VLAN priority bits
// - Sixteen-bit max and min range limits
`timescale 1ns/1ps
`include "acl4_consts.vh"
module acl4_layer4_top (
  input wire clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  output reg [7:0] reg_rdata_o,
  input wire pkt_valid_i,
  input wire [2:0] pkt_port_i,
  input wire pkt_tagged_i,
  input wire [15:0] pkt_l4_num_i,
  input wire [7:0] pkt_kind_i,
  input wire [7:0] pkt_flags_i,
  input wire [2:0] qos_prio_i,
  input wire [2:0] pkt_vlan_prio_i,
  output reg res_valid_o,
  output reg res_hit_o,
  output reg [2:0] res_prio_o,
  output reg [2:0] res_vlan_prio_o
);
  localparam NP = `ACL4_NUM_PORTS;

  // Per-port entry storage, one register per entry field
  reg [7:0] max_hi_r [0:NP-1];
  reg [7:0] max_lo_r [0:NP-1];
  reg [7:0] min_hi_r [0:NP-1];
  reg [7:0] min_lo_r [0:NP-1];
  reg [1:0] l4_range_compare_r [0:NP-1];
  reg [7:0] l4_ip_kind_value_r [0:NP-1];
  reg control_bits_match_on_r [0:NP-1];
  reg [7:0] tcp_control_bits_mask_r [0:NP-1];
  reg [7:0] tcp_control_bits_value_r [0:NP-1];
  reg [1:0] override_mode_r [0:NP-1];
  reg [2:0] entry_prio_r [0:NP-1];
  reg remark_enable_r [0:NP-1];
  reg [1:0] remark_level_r [0:NP-1];

  reg [7:0] cmd_r;
  reg [7:0] ofs_r;
  wire [2:0] sel_port;
  wire sel_ok;
  reg [7:0] entry_byte;
  integer i;

  // Port number 1..5 maps to entry 0..4; other values select nothing
  function [2:0] port_idx;
    input [3:0] p;
    begin
      port_idx = p[2:0] - 3'h1;
    end
  endfunction

  function port_ok;
    input [3:0] p;
    begin
      port_ok = (p >= 4'h1) && (p <= 4'h5);
    end
  endfunction

  assign sel_port = port_idx(cmd_r[3:0]);
  assign sel_ok = (cmd_r[7:5] == `ACL4_TABLE_SEL) && port_ok(cmd_r[3:0]);

  // Indirect byte read mux
  always @* begin
    entry_byte = 8'h00;
    if (sel_ok) begin
      case (ofs_r)
        `ACL4_OFS_MAX_HI: entry_byte = max_hi_r[sel_port];
        `ACL4_OFS_MAX_LO: entry_byte = max_lo_r[sel_port];
        `ACL4_OFS_MIN_HI: entry_byte = min_hi_r[sel_port];
        `ACL4_OFS_MIN_LO: entry_byte = min_lo_r[sel_port];
        `ACL4_OFS_RANGE_PROTO: entry_byte = {5'h00, l4_range_compare_r[sel_port],
                                             l4_ip_kind_value_r[sel_port][7]};
        `ACL4_OFS_PROTO_FLAG: entry_byte = {l4_ip_kind_value_r[sel_port][6:0],
                                            control_bits_match_on_r[sel_port]};
        `ACL4_OFS_FLAG_MASK: entry_byte = tcp_control_bits_mask_r[sel_port];
        `ACL4_OFS_FLAG_VALUE: entry_byte = tcp_control_bits_value_r[sel_port];
        `ACL4_OFS_ACTION: entry_byte = {override_mode_r[sel_port], entry_prio_r[sel_port],
                                        remark_enable_r[sel_port], remark_level_r[sel_port]};
        default: entry_byte = 8'h00;
      endcase
    end
  end

  // Register read data, registered; unmapped addresses read zero
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= `ACL4_RESET_BYTE;
    end else if (clk_en_i && reg_rd_i) begin
      case (reg_addr_i)
        `ACL4_REG_CMD: reg_rdata_o <= cmd_r;
        `ACL4_REG_OFS: reg_rdata_o <= ofs_r;
        `ACL4_REG_DATA: reg_rdata_o <= entry_byte;
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  // Register writes; bit 4 of the command register is unused and reads zero
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cmd_r <= `ACL4_RESET_BYTE;
      ofs_r <= `ACL4_RESET_BYTE;
      for (i = 0; i < NP; i = i + 1) begin
        max_hi_r[i] <= 8'h00;
        max_lo_r[i] <= 8'h00;
        min_hi_r[i] <= 8'h00;
        min_lo_r[i] <= 8'h00;
        l4_range_compare_r[i] <= 2'h0;
        l4_ip_kind_value_r[i] <= 8'h00;
        control_bits_match_on_r[i] <= 1'b0;
        tcp_control_bits_mask_r[i] <= 8'h00;
        tcp_control_bits_value_r[i] <= 8'h00;
        override_mode_r[i] <= 2'h0;
        entry_prio_r[i] <= 3'h0;
        remark_enable_r[i] <= 1'b0;
        remark_level_r[i] <= 2'h0;
      end
    end else if (clk_en_i && reg_wr_i) begin
      if (reg_addr_i == `ACL4_REG_CMD) begin
        cmd_r <= {reg_wdata_i[7:5], 1'b0, reg_wdata_i[3:0]};
      end
      if (reg_addr_i == `ACL4_REG_OFS) begin
        ofs_r <= reg_wdata_i;
      end
      if (reg_addr_i == `ACL4_REG_DATA && sel_ok) begin
        case (ofs_r)
          `ACL4_OFS_MAX_HI: max_hi_r[sel_port] <= reg_wdata_i;
          `ACL4_OFS_MAX_LO: max_lo_r[sel_port] <= reg_wdata_i;
          `ACL4_OFS_MIN_HI: min_hi_r[sel_port] <= reg_wdata_i;
          `ACL4_OFS_MIN_LO: min_lo_r[sel_port] <= reg_wdata_i;
          `ACL4_OFS_RANGE_PROTO: begin
            l4_range_compare_r[sel_port] <= reg_wdata_i[2:1];
            l4_ip_kind_value_r[sel_port][7] <= reg_wdata_i[0];
          end
          `ACL4_OFS_PROTO_FLAG: begin
            l4_ip_kind_value_r[sel_port][6:0] <= reg_wdata_i[7:1];
            control_bits_match_on_r[sel_port] <= reg_wdata_i[0];
          end
          `ACL4_OFS_FLAG_MASK: tcp_control_bits_mask_r[sel_port] <= reg_wdata_i;
          `ACL4_OFS_FLAG_VALUE: tcp_control_bits_value_r[sel_port] <= reg_wdata_i;
          `ACL4_OFS_ACTION: begin
            override_mode_r[sel_port] <= reg_wdata_i[7:6];
            entry_prio_r[sel_port] <= reg_wdata_i[5:3];
            remark_enable_r[sel_port] <= reg_wdata_i[2];
            remark_level_r[sel_port] <= reg_wdata_i[1:0];
          end
          default: ;
        endcase
      end
    end
  end

  // Packet path: the entry of the receiving port is evaluated
  wire [2:0] pk;
  wire pk_ok;
  wire hit;
  assign pk = port_idx({1'b0, pkt_port_i});
  assign pk_ok = port_ok({1'b0, pkt_port_i});

  acl4_match_eval u_eval (
    .max_val_i({max_hi_r[pk], max_lo_r[pk]}),
    .min_val_i({min_hi_r[pk], min_lo_r[pk]}),
    .range_mode_i(l4_range_compare_r[pk]),
    .kind_val_i(l4_ip_kind_value_r[pk]),
    .flag_on_i(control_bits_match_on_r[pk]),
    .flag_mask_i(tcp_control_bits_mask_r[pk]),
    .flag_val_i(tcp_control_bits_value_r[pk]),
    .pkt_l4_num_i(pkt_l4_num_i),
    .pkt_kind_i(pkt_kind_i),
    .pkt_flags_i(pkt_flags_i),
    .hit_o(hit)
  );

  // Priority choice; untagged frames keep the QoS result
  reg [2:0] prio_sel;
  reg [2:0] vlan_sel;
  wire [2:0] ep;
  assign ep = entry_prio_r[pk];
  always @* begin
    prio_sel = qos_prio_i;
    if (hit && pk_ok && pkt_tagged_i) begin
      case (override_mode_r[pk])
        `ACL4_PM_KEEP: prio_sel = qos_prio_i;
        `ACL4_PM_GREATER: prio_sel = (ep > qos_prio_i) ? ep : qos_prio_i;
        `ACL4_PM_SMALLER: prio_sel = (ep < qos_prio_i) ? ep : qos_prio_i;
        `ACL4_PM_REPLACE: prio_sel = ep;
        default: prio_sel = qos_prio_i;
      endcase
    end
    vlan_sel = pkt_vlan_prio_i;
    if (hit && pk_ok && remark_enable_r[pk]) begin
      vlan_sel = {1'b0, remark_level_r[pk]};
    end
  end

  // Result registered one cycle after the packet strobe
  always @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      res_valid_o <= 1'b0;
      res_hit_o <= 1'b0;
      res_prio_o <= 3'h0;
      res_vlan_prio_o <= 3'h0;
    end else if (clk_en_i) begin
      res_valid_o <= pkt_valid_i;
      if (pkt_valid_i) begin
        res_hit_o <= hit && pk_ok;
        res_prio_o <= prio_sel;
        res_vlan_prio_o <= vlan_sel;
      end
    end
  end
endmodule // acl4_layer4_top

// ### acl4_consts.vh
`ifndef ACL4_CONSTS_VH
`define ACL4_CONSTS_VH
// Indirect access register addresses
`define ACL4_REG_CMD 8'h6E
`define ACL4_REG_OFS 8'h6F
`define ACL4_REG_DATA 8'hA0
`define ACL4_TABLE_SEL 3'h2
// Entry byte offsets
`define ACL4_OFS_MAX_HI 8'h00
`define ACL4_OFS_MAX_LO 8'h01
`define ACL4_OFS_MIN_HI 8'h02
`define ACL4_OFS_MIN_LO 8'h03
`define ACL4_OFS_RANGE_PROTO 8'h04
`define ACL4_OFS_PROTO_FLAG 8'h05
`define ACL4_OFS_FLAG_MASK 8'h06
`define ACL4_OFS_FLAG_VALUE 8'h07
`define ACL4_OFS_RSVD_A 8'h08
`define ACL4_OFS_RSVD_B 8'h09
`define ACL4_OFS_ACTION 8'h0A
// Range compare modes
`define ACL4_RC_OFF 2'h0
`define ACL4_RC_EITHER 2'h1
`define ACL4_RC_INSIDE 2'h2
`define ACL4_RC_OUTSIDE 2'h3
// Priority override modes
`define ACL4_PM_KEEP 2'h0
`define ACL4_PM_GREATER 2'h1
`define ACL4_PM_SMALLER 2'h2
`define ACL4_PM_REPLACE 2'h3
`define ACL4_NUM_PORTS 5
`define ACL4_RESET_BYTE 8'h00
`endif

// ### acl4_match_eval.v
`timescale 1ns/1ps
`include "acl4_consts.vh"
module acl4_match_eval (
  input wire [15:0] max_val_i,
  input wire [15:0] min_val_i,
  input wire [1:0] range_mode_i,
  input wire [7:0] kind_val_i,
  input wire flag_on_i,
  input wire [7:0] flag_mask_i,
  input wire [7:0] flag_val_i,
  input wire [15:0] pkt_l4_num_i,
  input wire [7:0] pkt_kind_i,
  input wire [7:0] pkt_flags_i,
  output wire hit_o
);
  wire range_ok;
  wire kind_ok;
  wire flag_ok;
  reg rng;
  wire in_range;

  // Inclusive at both limits
  assign in_range = (pkt_l4_num_i >= min_val_i) && (pkt_l4_num_i <= max_val_i);

  always @* begin
    case (range_mode_i)
      `ACL4_RC_OFF: rng = 1'b1;
      `ACL4_RC_EITHER: rng = (pkt_l4_num_i == max_val_i) || (pkt_l4_num_i == min_val_i);
      `ACL4_RC_INSIDE: rng = in_range;
      `ACL4_RC_OUTSIDE: rng = !in_range;
      default: rng = 1'b1;
    endcase
  end
  assign range_ok = rng;

  assign kind_ok = (pkt_kind_i == kind_val_i);
  assign flag_ok = !flag_on_i || ((pkt_flags_i & flag_mask_i) == (flag_val_i & flag_mask_i));
  assign hit_o = kind_ok && range_ok && flag_ok;
endmodule // acl4_match_eval

// ### acl4_layer4_monitor.sv
`timescale 1ns/1ps
module acl4_layer4_monitor (
  input wire clk_i,
  input wire sys_rst_i,
  input wire clk_en_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire [7:0] reg_rdata_o,
  input wire pkt_valid_i,
  input wire [2:0] pkt_port_i,
  input wire pkt_tagged_i,
  input wire [15:0] pkt_l4_num_i,
  input wire [7:0] pkt_kind_i,
  input wire [7:0] pkt_flags_i,
  input wire [2:0] qos_prio_i,
  input wire [2:0] pkt_vlan_prio_i,
  input wire res_valid_o,
  input wire res_hit_o,
  input wire [2:0] res_prio_o,
  input wire [2:0] res_vlan_prio_o
);
  // One domain, so clock and reset once
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Accepted lookups and reads
  wire tk = clk_en_i & pkt_valid_i;
  wire rd = clk_en_i & reg_rd_i;
  a_result_follows: assert property (tk |=> res_valid_o) else $error("no result");
  a_result_stray: assert property (clk_en_i && !pkt_valid_i |=> !res_valid_o)
    else $error("stray result");
  a_frozen_hold: assert property (!clk_en_i |=>
    $stable({res_valid_o, res_hit_o, res_prio_o, res_vlan_prio_o, reg_rdata_o}))
    else $error("frozen output moved");
  a_result_hold: assert property (!res_valid_o |->
    $stable({res_hit_o, res_prio_o, res_vlan_prio_o})) else $error("result moved");
  a_foreign_port: assert property (tk && (pkt_port_i == 3'h0 || pkt_port_i > 3'h5)
    |=> !res_hit_o) else $error("bad port hit");
  a_miss_vlan: assert property (res_valid_o && !res_hit_o
    |-> res_vlan_prio_o == $past(pkt_vlan_prio_i)) else $error("vlan changed");
  a_keep_qos: assert property (res_valid_o && !(res_hit_o && $past(pkt_tagged_i))
    |-> res_prio_o == $past(qos_prio_i)) else $error("prio changed");
  a_unmapped_zero: assert property (rd && !(reg_addr_i inside {8'h6E, 8'h6F, 8'hA0})
    |=> reg_rdata_o == 8'h00) else $error("unmapped data");
  a_rdata_hold: assert property (!rd |=> $stable(reg_rdata_o)) else $error("rdata moved");
  a_cmd_bit4: assert property (rd && reg_addr_i == 8'h6E |=> !reg_rdata_o[4])
    else $error("cmd bit4 set");
  // Main scenarios seen
  c_hit: cover property (res_valid_o && res_hit_o);
  c_miss: cover property (res_valid_o && !res_hit_o);
  c_read: cover property (rd ##1 reg_rdata_o != 8'h00);
endmodule // acl4_layer4_monitor
bind acl4_layer4_top acl4_layer4_monitor u_mon (.*);

// ### acl4_layer4_top_tb.sv
`timescale 1ns/1ps
module acl4_layer4_top_tb;
  // Inputs set at time zero
  reg clk_i = 0, sys_rst_i = 1, clk_en_i = 1, reg_wr_i = 0, reg_rd_i = 0;
  reg pkt_valid_i = 0, pkt_tagged_i = 0;
  reg [7:0] reg_addr_i = 0, reg_wdata_i = 0, pkt_kind_i = 0, pkt_flags_i = 0;
  reg [2:0] pkt_port_i = 0, qos_prio_i = 0, pkt_vlan_prio_i = 0;
  reg [15:0] pkt_l4_num_i = 0;
  wire [7:0] reg_rdata_o;
  wire res_valid_o, res_hit_o;
  wire [2:0] res_prio_o, res_vlan_prio_o;
  // Bench image of the entry bytes
  reg [7:0] cfg [0:10];
  reg [2:0] ep;
  // Protocol held by each port's entry, so stray ports can be kept from hitting
  reg [7:0] kp [0:7];
  integer mismatches = 0, n_tests = 0, cyc = 0, k, j, o;
  wire [15:0] mx = {cfg[0], cfg[1]}, mn = {cfg[2], cfg[3]};
  wire [7:0] pr = {cfg[4][0], cfg[5][7:1]};
  wire [1:0] rc = cfg[4][2:1], pm = cfg[10][7:6], rl = cfg[10][1:0];
  wire [2:0] pp = cfg[10][5:3];
  wire fe = cfg[5][0], re = cfg[10][2];
  acl4_layer4_top dut (.*);
  initial forever #25 clk_i = ~clk_i;
  // Hang guard, far above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  task end_sim;
    begin
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task chk(input string n, input [7:0] e, input [7:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("wrong value %0s exp %h got %h", n, e, g);
      end
    end
  endtask
  // Strobe drops a cycle later, so calls never collide
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1;
      @(posedge clk_i);
      reg_wr_i <= 0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] e);
    begin
      @(posedge clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1;
      @(posedge clk_i);
      reg_rd_i <= 0;
      @(negedge clk_i);
      chk("rdata", e, reg_rdata_o); // read data
    end
  endtask
  function hit(input [2:0] p, input [15:0] n, input [7:0] kd, input [7:0] fl);
    reg ins;
    begin
      ins = n >= mn && n <= mx;
      hit = p == ep && kd == pr && (!fe || (fl & cfg[6]) == (cfg[7] & cfg[6])) && (rc == 0
        || rc == 1 && (n == mx || n == mn) || rc == 2 && ins || rc == 3 && !ins);
    end
  endfunction
  function [2:0] pri(input h, input t, input [2:0] q);
    pri = !(h && t) || pm == 0 ? q : pm == 3 ? pp : (pm == 1 ? pp > q : pp < q) ? pp : q;
  endfunction
  task pk(input [2:0] p, input [15:0] n, input [7:0] kd, input [7:0] fl);
    reg h, t;
    reg [2:0] q, v;
    begin
      {q, v, t} = $urandom;
      // Another port's entry is not modelled, so its protocol test must fail
      if (p != ep && kd == kp[p])
        kd = ~kd;
      h = hit(p, n, kd, fl);
      @(posedge clk_i);
      {pkt_port_i, pkt_l4_num_i, pkt_kind_i, pkt_flags_i} <= {p, n, kd, fl};
      {qos_prio_i, pkt_vlan_prio_i, pkt_tagged_i, pkt_valid_i} <= {q, v, t, 1'b1};
      @(posedge clk_i);
      pkt_valid_i <= 0;
      @(negedge clk_i);
      chk("res", {1'b1, h, pri(h, t, q), (h && re) ? {1'b0, rl} : v},
        {res_valid_o, res_hit_o, res_prio_o, res_vlan_prio_o});
    end
  endtask
  initial begin
    k = $urandom(5);
    for (o = 0; o < 8; o = o + 1)
      kp[o] = 8'h00;
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 0;
    wr(8'h6E, 8'h51);
    rd(8'h6E, 8'h41); // command readback
    wr(8'h6F, 8'h0A);
    rd(8'hA0, 8'h00); // reset value
    rd(8'h55, 8'h00); // unmapped address
    // Every range mode against every priority mode
    for (k = 0; k < 16; k = k + 1) begin
      ep = 1 + $urandom % 5;
      for (o = 0; o < 11; o = o + 1)
        cfg[o] = $urandom;
      cfg[2] = cfg[2] >> 1;
      {cfg[0], cfg[1]} = {cfg[2], cfg[3]} + $urandom % 40;
      cfg[4][2:1] = k;
      cfg[10][7:6] = k >> 2;
      // all Layer 4 fields in one entry
      for (o = 0; o < 11; o = o + 1) begin
        wr(8'h6E, 8'h40 | ep);
        wr(8'h6F, o);
        wr(8'hA0, cfg[o]);
        rd(8'hA0, o == 4 ? cfg[o] & 8'h07 : o == 8 || o == 9 ? 8'h00 : cfg[o]);
      end
      // Wrong table select leaves the entry alone
      wr(8'h6E, 8'h60 | ep);
      wr(8'hA0, ~cfg[10]);
      wr(8'h6E, 8'h40 | ep);
      rd(8'hA0, cfg[10]); // refused write
      kp[ep] = pr;
      for (j = 0; j < 24; j = j + 1)
        pk(j % 4 ? ep : $urandom, j % 3 == 0 ? $urandom : j % 3 == 1 ? mx + j % 2 : mn - j % 2,
          j % 5 ? pr : $urandom, j % 2 ? cfg[7] : $urandom);
    end
    // Lookup while the clock enable is low is not taken
    @(posedge clk_i);
    clk_en_i <= 0;
    pkt_valid_i <= 1;
    reg_addr_i <= 8'hA0;
    reg_wdata_i <= ~cfg[10];
    reg_wr_i <= 1;
    @(posedge clk_i);
    clk_en_i <= 1;
    pkt_valid_i <= 0;
    reg_wr_i <= 0;
    @(negedge clk_i);
    chk("frozen", 8'h00, {7'h00, res_valid_o}); // frozen lookup
    rd(8'hA0, cfg[10]); // frozen write ignored
    end_sim;
  end
endmodule // acl4_layer4_top_tb
